// ===== src/button_mode_controller.sv
// Button-driven operating mode controller with APB register access
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module button_mode_controller (
  input  wire logic                      ref_clk_i,      // 100 MHz clock
  input  wire logic                      srst_i,         // Sync reset, high
  input  wire logic                      psel_i,         // APB select
  input  wire logic                      penable_i,      // APB enable
  input  wire logic                      pwrite_i,       // APB write
  input  wire logic [7:0]                paddr_i,        // APB byte address
  input  wire logic [31:0]               pwdata_i,       // APB write data
  output logic                           pready_o,       // APB ready
  output logic [31:0]                    prdata_o,       // APB read data
  output logic                           pslverr_o,      // APB error
  input  wire mode_ctrl_pkg::wake_pins_s pins_i,         // Asynchronous pins
  input  wire logic                      limit_exceed_i, // Sensor out of limits
  input  wire logic                      tx_done_i,      // Uplink finished pulse
  input  wire logic                      tx_reply_i,     // Network replied
  input  wire logic [6:0]                rssi_pct_i,     // Strength percent
  input  wire logic                      resend_i,       // Response asks resend
  input  wire logic                      radio_conn_i,   // Short radio connected
  input  wire logic                      equil_i,        // Sensors equilibrated
  input  wire logic                      lock_nv_i,      // Stored lock at boot
  output logic                           lock_nv_o,      // Lock to store
  output mode_ctrl_pkg::mode_e           mode_o,         // Current mode
  output mode_ctrl_pkg::glyph_e          glyph_o,        // Display glyph
  output logic [7:0]                     clicks_o,       // Click count shown
  output logic [6:0]                     strength_o,     // Strength percent
  output logic                           radio_adv_o,    // Short radio on
  output logic                           powered_o,      // Functions powered
  output logic                           awake_o,        // Woken from sleep
  output mode_ctrl_pkg::strobes_s        strobes_o       // Action pulses
);

  // ----------
  // Pin synchronisers
  // ----------
  mode_ctrl_pkg::wake_pins_s meta_q, sync_q, prev_q;  // Two stages plus history
  logic lock_meta_q, lock_sync_q;                     // Stored lock strap sync

  // Stage one is read only by stage two
  always_ff @(posedge ref_clk_i)
  begin
    meta_q      <= pins_i;
    sync_q      <= meta_q;
    prev_q      <= sync_q;
    lock_meta_q <= lock_nv_i;
    lock_sync_q <= lock_meta_q;
  end

  wire btn_press  = sync_q.button & ~prev_q.button;
  wire optic_edge = sync_q.optic ^ prev_q.optic;
  wire door_edge  = sync_q.door ^ prev_q.door;
  wire plug_edge  = sync_q.plug & ~prev_q.plug;
  wire dongle_in  = sync_q.dongle & ~prev_q.dongle;

  // ----------
  // Registers and APB slave
  // ----------
  logic [31:0] ctrl_q, check_q, log_q, uplink_q, idle_q, tout_q;
  logic [1:0]  boot_q;  // Boot phase: strap caught after reset release

  wire apb_acc = psel_i & penable_i;
  wire apb_wr  = apb_acc & pwrite_i;
  wire hit_ctrl   = paddr_i == mode_ctrl_pkg::ADDR_CTRL;
  wire hit_status = paddr_i == mode_ctrl_pkg::ADDR_STATUS;
  wire hit_check  = paddr_i == mode_ctrl_pkg::ADDR_CHECK;
  wire hit_log    = paddr_i == mode_ctrl_pkg::ADDR_LOG;
  wire hit_uplink = paddr_i == mode_ctrl_pkg::ADDR_UPLINK;
  wire hit_idle   = paddr_i == mode_ctrl_pkg::ADDR_IDLE;
  wire hit_tout   = paddr_i == mode_ctrl_pkg::ADDR_TOUT;
  wire hit_result = paddr_i == mode_ctrl_pkg::ADDR_RESULT;
  wire hit_any = hit_ctrl | hit_status | hit_check | hit_log | hit_uplink | hit_idle | hit_tout | hit_result;

  logic [3:0] cal_cnt_q;  // Calibration points taken
  wire [31:0] rd_mux =
      hit_ctrl   ? ctrl_q :
      hit_status ? {17'h0_0000, glyph_o, clicks_o, mode_o} :
      hit_check  ? check_q :
      hit_log    ? log_q :
      hit_uplink ? uplink_q :
      hit_idle   ? idle_q :
      hit_tout   ? tout_q :
      hit_result ? {21'h00_0000, cal_cnt_q, strength_o} : 32'h0000_0000;

  // Register writes land at the end of the first access cycle, on the edge that raises ready
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      ctrl_q   <= 32'h0000_0000;
      check_q  <= mode_ctrl_pkg::CHECK_RST;
      log_q    <= mode_ctrl_pkg::LOG_RST;
      uplink_q <= mode_ctrl_pkg::UPLINK_RST;
      idle_q   <= mode_ctrl_pkg::IDLE_RST;
      tout_q   <= mode_ctrl_pkg::TOUT_RST;
    end
    else if (apb_wr)
    begin
      if (hit_ctrl)   ctrl_q   <= pwdata_i;
      if (hit_check)  check_q  <= pwdata_i;
      if (hit_log)    log_q    <= pwdata_i;
      if (hit_uplink) uplink_q <= pwdata_i;
      if (hit_idle)   idle_q   <= pwdata_i;
      if (hit_tout)   tout_q   <= pwdata_i;
    end
  end

  // Registered answer: ready and data appear one cycle into the access phase
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= apb_acc & ~pready_o;
      prdata_o  <= (apb_acc & ~pwrite_i) ? rd_mux : 32'h0000_0000;
      pslverr_o <= apb_acc & ~pready_o & ~hit_any;
    end
  end

  // ----------
  // Click counter and idle detector
  // ----------
  logic [31:0] idle_cnt_q, tout_cnt_q;  // Press idle and mode timeout cycles
  logic        pending_q;    // A click sequence is open
  logic [31:0] chk_cnt_q, log_cnt_q, up_cnt_q;
  logic        listen_q;     // Waiting for uplink response

  wire in_cal   = mode_o == mode_ctrl_pkg::MODE_CAL;
  wire press_ok = btn_press & ~in_cal & (boot_q == 2'h3);
  wire seq_done = pending_q & ~press_ok & (idle_cnt_q >= idle_q);

  // Classification of a finished count
  wire n_one  = clicks_o == mode_ctrl_pkg::CLICKS_ONE;
  wire n_two  = clicks_o == mode_ctrl_pkg::CLICKS_TWO;
  wire n_ten  = clicks_o >= mode_ctrl_pkg::CLICKS_TEN;
  wire n_lock = clicks_o >= mode_ctrl_pkg::CLICKS_LOCK;

  wire run_like = (mode_o == mode_ctrl_pkg::MODE_RUN) | (mode_o == mode_ctrl_pkg::MODE_RADIO);
  wire chk_hit  = run_like & (chk_cnt_q >= check_q);
  wire log_hit  = run_like & (log_cnt_q >= log_q);
  wire up_hit   = run_like & (up_cnt_q >= uplink_q) & ~listen_q;
  wire optic_ev = optic_edge & ctrl_q[mode_ctrl_pkg::CTRL_OPTIC_EN_BIT] & powered_o;
  wire tout_hit = tout_cnt_q >= tout_q;

  // ----------
  // Mode machine
  // ----------
  mode_ctrl_pkg::mode_e  mode_d;
  mode_ctrl_pkg::glyph_e glyph_d;
  mode_ctrl_pkg::strobes_s stb_d;
  logic adv_d, test_d, test_q;  // Advertise next, test uplink outstanding

  always_comb
  begin
    mode_d  = mode_o;
    glyph_d = glyph_o;
    stb_d   = '0;
    adv_d   = radio_adv_o;
    test_d  = test_q;
    if (press_ok) glyph_d = mode_ctrl_pkg::GLYPH_COUNT;
    if (seq_done)
    begin
      unique case (mode_o)
        mode_ctrl_pkg::MODE_RUN, mode_ctrl_pkg::MODE_RADIO:
        begin
          if (n_ten)
          begin
            mode_d  = mode_ctrl_pkg::MODE_OFF;
            glyph_d = mode_ctrl_pkg::GLYPH_OFF;
            adv_d   = 1'b0;
          end
          else if (n_one)
          begin
            mode_d  = mode_ctrl_pkg::MODE_RADIO;
            glyph_d = mode_ctrl_pkg::GLYPH_READINGS;
            adv_d   = 1'b1;
            stb_d.log_rec = ctrl_q[mode_ctrl_pkg::CTRL_LOG_EN_BIT];
          end
          else if (n_two)
          begin
            glyph_d = mode_ctrl_pkg::GLYPH_TRANSMIT;
            stb_d.test_tx = 1'b1;
            test_d  = 1'b1;
          end
        end
        mode_ctrl_pkg::MODE_OFF:
        begin
          if (n_lock)
          begin
            mode_d  = mode_ctrl_pkg::MODE_LOCK;
            glyph_d = mode_ctrl_pkg::GLYPH_SHIPPING_HOLD;
          end
          else if (n_ten)
          begin
            mode_d  = mode_ctrl_pkg::MODE_RUN;
            glyph_d = mode_ctrl_pkg::GLYPH_RUN;
          end
          else glyph_d = mode_ctrl_pkg::GLYPH_OFF;
        end
        mode_ctrl_pkg::MODE_LOCK:
        begin
          if (n_lock)
          begin
            mode_d  = mode_ctrl_pkg::MODE_OFF;
            glyph_d = mode_ctrl_pkg::GLYPH_OFF;
          end
          else glyph_d = mode_ctrl_pkg::GLYPH_SHIPPING_HOLD;
        end
        mode_ctrl_pkg::MODE_CAL:
          glyph_d = glyph_o;
      endcase
    end
    // Test uplink result
    if (test_q & tx_done_i)
    begin
      test_d  = 1'b0;
      glyph_d = tx_reply_i ? mode_ctrl_pkg::GLYPH_STRENGTH : mode_ctrl_pkg::GLYPH_NO_NETWORK;
    end
    // Radio fail safe: no connection held until timeout
    if (mode_o == mode_ctrl_pkg::MODE_RADIO & ~radio_conn_i & tout_hit & ~seq_done)
    begin
      mode_d = mode_ctrl_pkg::MODE_RUN;
      adv_d  = 1'b0;
    end
    // Dongle takes priority over clicks while powered
    if (dongle_in & run_like)
    begin
      mode_d = mode_ctrl_pkg::MODE_CAL;
      adv_d  = 1'b0;
    end
    if (in_cal)
    begin
      stb_d.cal_pt = equil_i & (cal_cnt_q < mode_ctrl_pkg::CAL_POINTS_MAX);
      if (tout_hit) mode_d = mode_ctrl_pkg::MODE_RUN;
    end
    if (run_like & (chk_hit & limit_exceed_i))
    begin
      stb_d.log_rec  = 1'b1;
      stb_d.alert_tx = 1'b1;
    end
    if (log_hit) stb_d.log_rec = 1'b1;
    if (up_hit | (listen_q & tx_done_i & resend_i)) stb_d.uplink = 1'b1;
    if (optic_ev)
    begin
      stb_d.log_rec = 1'b1;
      glyph_d = sync_q.optic ? mode_ctrl_pkg::GLYPH_OPEN : mode_ctrl_pkg::GLYPH_CLOSED;
    end
    // Lock state read back from storage wins at boot
    if (boot_q == 2'h1)
    begin
      mode_d  = lock_sync_q ? mode_ctrl_pkg::MODE_LOCK : mode_ctrl_pkg::MODE_OFF;
      glyph_d = lock_sync_q ? mode_ctrl_pkg::GLYPH_SHIPPING_HOLD : mode_ctrl_pkg::GLYPH_OFF;
    end
  end

  // ----------
  // State registers
  // ----------
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      mode_o      <= mode_ctrl_pkg::MODE_OFF;
      glyph_o     <= mode_ctrl_pkg::GLYPH_BLANK;
      strobes_o   <= '0;
      radio_adv_o <= 1'b0;
      test_q      <= 1'b0;
      boot_q      <= 2'h0;
    end
    else
    begin
      mode_o      <= mode_d;
      glyph_o     <= glyph_d;
      strobes_o   <= stb_d;
      radio_adv_o <= adv_d;
      test_q      <= test_d;
      if (boot_q != 2'h3) boot_q <= boot_q + 2'h1;
    end
  end

  // Off and lock keep only the button alive
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      powered_o <= 1'b0;
      lock_nv_o <= 1'b0;
      awake_o   <= 1'b0;
    end
    else
    begin
      powered_o <= (mode_d != mode_ctrl_pkg::MODE_OFF) & (mode_d != mode_ctrl_pkg::MODE_LOCK);
      lock_nv_o <= mode_d == mode_ctrl_pkg::MODE_LOCK;
      awake_o   <= btn_press | (powered_o & (optic_ev | door_edge | plug_edge));
    end
  end

  // Click counting, saturating so long press runs cannot wrap
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      clicks_o   <= 8'h00;
      pending_q  <= 1'b0;
      idle_cnt_q <= 32'h0000_0000;
    end
    else if (press_ok)
    begin
      if (clicks_o != mode_ctrl_pkg::CLICKS_MAX)
        clicks_o <= clicks_o + 8'h01;
      pending_q  <= 1'b1;
      idle_cnt_q <= 32'h0000_0000;
    end
    else if (seq_done | in_cal)
    begin
      clicks_o  <= 8'h00;
      pending_q <= 1'b0;
    end
    else if (pending_q) idle_cnt_q <= idle_cnt_q + 32'h1;
  end

  // Interval timers, all reset outside run and radio modes
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i | ~run_like)
    begin
      chk_cnt_q <= 32'h0;
      log_cnt_q <= 32'h0;
      up_cnt_q  <= 32'h0;
      listen_q  <= 1'b0;
    end
    else
    begin
      chk_cnt_q <= chk_hit ? 32'h0 : chk_cnt_q + 32'h1;
      log_cnt_q <= log_hit ? 32'h0 : log_cnt_q + 32'h1;
      up_cnt_q  <= up_hit ? 32'h0 : up_cnt_q + 32'h1;
      if (up_hit) listen_q <= 1'b1;
      else if (tx_done_i & ~resend_i) listen_q <= 1'b0;
    end
  end

  // Shared timeout for radio and calibration modes, plus result capture
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      tout_cnt_q <= 32'h0000_0000;
      cal_cnt_q  <= 4'h0;
      strength_o <= 7'h00;
    end
    else
    begin
      if (mode_d != mode_o | radio_conn_i | press_ok) tout_cnt_q <= 32'h0;
      else if (mode_o == mode_ctrl_pkg::MODE_RADIO | in_cal) tout_cnt_q <= tout_cnt_q + 32'h1;
      if (dongle_in & run_like) cal_cnt_q <= 4'h0;
      else if (stb_d.cal_pt) cal_cnt_q <= cal_cnt_q + 4'h1;
      if (test_q & tx_done_i & tx_reply_i)
        strength_o <= (rssi_pct_i > mode_ctrl_pkg::PCT_MAX) ? mode_ctrl_pkg::PCT_MAX : rssi_pct_i;
    end
  end

endmodule
`default_nettype wire

// ===== src/mode_ctrl_pkg.sv
// Constants, register map, enums and carriers of the mode controller
//
// Operation
// - Run, one click: show readings, radio advertises
// - Single click logs record when setting enabled
// - Run, two clicks: transmit glyph, test, show strength
// - No network reply shows no-network glyph
// - Run, ten or more clicks: off mode
// - Off, ten to nineteen clicks: run mode
// - Off, one to nine clicks: stay off
// - Off, twenty or more: shipping lock
// - Lock keeps below twenty; twenty unlocks off
// - Presses count up; act after presses stop
// - Calibration mode ignores the push button
// - Locked state survives power-loss reboot
// - Off mode powers down all but button
// - Run check interval: limits, log, alert
// - Run logging interval stores sensor values
// - Uplink interval: send, listen, resend or sleep
// - Wake on button, optic, door, plug events
// - Radio mode times out back to run
// - Dongle plugged in enters calibration mode
// - Acquire point when equilibrated, ten maximum
// - Calibration timeout returns to run
// - Optic event logged, open/closed glyph shown
`default_nettype none
package mode_ctrl_pkg;

  // ----------
  // Register offsets (byte addresses)
  // ----------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;  // Enables
  localparam logic [7:0] ADDR_STATUS = 8'h04;  // Mode, click count, glyph
  localparam logic [7:0] ADDR_CHECK  = 8'h08;  // Check interval, cycles
  localparam logic [7:0] ADDR_LOG    = 8'h0C;  // Log interval, cycles
  localparam logic [7:0] ADDR_UPLINK = 8'h10;  // Uplink interval, cycles
  localparam logic [7:0] ADDR_IDLE   = 8'h14;  // Click idle, cycles
  localparam logic [7:0] ADDR_TOUT   = 8'h18;  // Radio/calibration timeout
  localparam logic [7:0] ADDR_RESULT = 8'h1C;  // Signal strength, cal points

  // ----------
  // Field positions and reset values
  // ----------
  localparam int CTRL_LOG_EN_BIT   = 0;  // Log on single click
  localparam int CTRL_OPTIC_EN_BIT = 1;  // Optic detection enable
  localparam logic [31:0] CHECK_RST  = 32'h0000_1000;
  localparam logic [31:0] LOG_RST    = 32'h0000_2000;
  localparam logic [31:0] UPLINK_RST = 32'h0000_4000;
  localparam logic [31:0] IDLE_RST   = 32'h0000_0100;
  localparam logic [31:0] TOUT_RST   = 32'h0000_0800;

  // ----------
  // Click thresholds and limits
  // ----------
  localparam logic [7:0] CLICKS_ONE  = 8'h01;
  localparam logic [7:0] CLICKS_TWO  = 8'h02;
  localparam logic [7:0] CLICKS_TEN  = 8'h0A;
  localparam logic [7:0] CLICKS_LOCK = 8'h14;
  localparam logic [7:0] CLICKS_MAX  = 8'hFF;
  localparam logic [3:0] CAL_POINTS_MAX = 4'hA;
  localparam logic [6:0] PCT_MAX = 7'h64;

  // ----------
  // Enumerations and carriers
  // ----------
  typedef enum logic [2:0] {MODE_RUN, MODE_OFF, MODE_LOCK, MODE_RADIO, MODE_CAL} mode_e;

  typedef enum logic [3:0] {
    GLYPH_BLANK, GLYPH_COUNT, GLYPH_READINGS, GLYPH_TRANSMIT, GLYPH_STRENGTH,
    GLYPH_NO_NETWORK, GLYPH_OFF, GLYPH_RUN, GLYPH_SHIPPING_HOLD, GLYPH_OPEN, GLYPH_CLOSED
  } glyph_e;

  typedef struct packed {
    logic button;  // Push button level
    logic optic;   // Light level
    logic door;    // Door switch level
    logic plug;    // External device present
    logic dongle;  // Calibration dongle present
  } wake_pins_s;

  typedef struct packed {
    logic log_rec;   // Write one log record
    logic alert_tx;  // Start an alert uplink
    logic test_tx;   // Start a test uplink
    logic uplink;    // Start a log uplink
    logic cal_pt;    // Acquire a calibration point
  } strobes_s;

endpackage
`default_nettype wire

// ===== tb/button_mode_checker.sv
// Concurrent checks on the button mode controller ports
`timescale 1ns/1ps
`default_nettype none
module button_mode_checker (
  input wire logic                    ref_clk_i,   // Clock
  input wire logic                    srst_i,      // Sync reset
  input wire logic                    tx_done_i,   // Uplink done
  input wire logic                    tx_reply_i,  // Network replied
  input wire logic [6:0]              rssi_pct_i,  // Raw strength
  input wire mode_ctrl_pkg::mode_e    mode_o,      // Mode
  input wire mode_ctrl_pkg::glyph_e   glyph_o,     // Glyph
  input wire logic [7:0]              clicks_o,    // Click count
  input wire logic [6:0]              strength_o,  // Shown strength
  input wire logic                    radio_adv_o, // Short radio on
  input wire logic                    powered_o,   // Powered
  input wire mode_ctrl_pkg::strobes_s strobes_o    // Action pulses
);
  // ----------
  // Helper state
  // ----------
  logic       pend_q;  // Test uplink awaiting its answer
  logic [4:0] cal_q;   // Points taken in this calibration stay
  // Both clear on reset so a stale answer never counts
  always_ff @(posedge ref_clk_i)
  begin
    pend_q <= !srst_i && (strobes_o.test_tx || (pend_q && !tx_done_i));
    cal_q  <= (srst_i || mode_o != mode_ctrl_pkg::MODE_CAL) ? 5'h00 : cal_q + 5'(strobes_o.cal_pt);
  end
  // ----------
  // Assertions
  // ----------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  a_off_dark:
    assert property (mode_o == mode_ctrl_pkg::MODE_OFF && $stable(mode_o)
      |-> !powered_o && strobes_o == 5'h00) else $error("off mode not dark");
  a_lock_glyph:
    assert property ($changed(mode_o) && mode_o == mode_ctrl_pkg::MODE_LOCK
      |-> glyph_o == mode_ctrl_pkg::GLYPH_SHIPPING_HOLD) else $error("lock without hold glyph");
  a_off_glyph:
    assert property ($changed(mode_o) && mode_o == mode_ctrl_pkg::MODE_OFF
      |-> glyph_o == mode_ctrl_pkg::GLYPH_OFF) else $error("off without off glyph");
  a_radio_entry:
    assert property ($past(mode_o) == mode_ctrl_pkg::MODE_RUN && mode_o == mode_ctrl_pkg::MODE_RADIO
      |-> glyph_o == mode_ctrl_pkg::GLYPH_READINGS ##1 radio_adv_o) else $error("radio entry wrong");
  a_cal_deaf:
    assert property (mode_o == mode_ctrl_pkg::MODE_CAL && $stable(mode_o)
      |-> clicks_o <= $past(clicks_o)) else $error("click counted in calibration");
  a_tx_glyph:
    assert property (strobes_o.test_tx |-> glyph_o == mode_ctrl_pkg::GLYPH_TRANSMIT)
      else $error("test uplink without transmit glyph");
  a_strength_shown:
    assert property (pend_q && tx_done_i && tx_reply_i |=> glyph_o == mode_ctrl_pkg::GLYPH_STRENGTH
      && strength_o == ($past(rssi_pct_i) > 7'h64 ? 7'h64 : $past(rssi_pct_i))) else $error("strength wrong");
  a_no_network:
    assert property (pend_q && tx_done_i && !tx_reply_i |=> glyph_o == mode_ctrl_pkg::GLYPH_NO_NETWORK)
      else $error("missing no-network glyph");
  a_cal_limit:
    assert property (cal_q <= 5'h0A) else $error("too many calibration points");
  // Main scenarios reached
  c_lock: cover property (mode_o == mode_ctrl_pkg::MODE_LOCK);
  c_cal: cover property (strobes_o.cal_pt);
  c_no_net: cover property (glyph_o == mode_ctrl_pkg::GLYPH_NO_NETWORK);
endmodule
bind button_mode_controller button_mode_checker button_mode_checker_inst (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .tx_done_i(tx_done_i), .tx_reply_i(tx_reply_i),
  .rssi_pct_i(rssi_pct_i), .mode_o(mode_o), .glyph_o(glyph_o), .clicks_o(clicks_o),
  .strength_o(strength_o), .radio_adv_o(radio_adv_o), .powered_o(powered_o), .strobes_o(strobes_o));
`default_nettype wire

// ===== tb/radio_partner.sv
// Far-side model of the long range radio and its network
`timescale 1ns/1ps
`default_nettype none
module radio_partner (
  input  wire logic                    ref_clk_i,  // Clock
  input  wire mode_ctrl_pkg::strobes_s strobes_i,  // Uplink requests
  input  wire logic                    reply_en_i, // Network in reach
  input  wire logic [6:0]              rssi_set_i, // Strength to report
  input  wire logic [3:0]              delay_i,    // Extra answer delay
  output logic                         tx_done_o,  // Done pulse
  output logic                         tx_reply_o, // Reply flag
  output logic [6:0]                   rssi_o      // Reported strength
);
  int wait_q = 0;  // Cycles left to the answer, 0 when idle
  // Flag and strength mean nothing outside the done pulse, so they churn there
  always @(posedge ref_clk_i)
  begin
    tx_done_o  <= wait_q == 1;
    tx_reply_o <= wait_q == 1 ? reply_en_i : !tx_reply_o;
    rssi_o     <= wait_q == 1 ? rssi_set_i : ~rssi_o;
    if (strobes_i.test_tx || strobes_i.uplink)
      wait_q <= 2 + delay_i;  // Air time plus receive window
    else if (wait_q > 0)
      wait_q <= wait_q - 1;
  end
endmodule
`default_nettype wire

// ===== tb/tb_button_mode_controller.sv
// Self-checking bench for the button mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_button_mode_controller;
  logic        ref_clk_i = 1'b0;  // 100 MHz clock
  logic        srst_i = 1'b1;     // Reset
  logic        psel = 1'b0;       // APB select
  logic        penable = 1'b0;    // APB enable
  logic        pwrite = 1'b0;     // APB direction
  logic [7:0]  paddr = 8'h00;     // APB address
  logic [31:0] pwdata = 32'h0;    // APB write data
  logic        limit_q = 1'b0;    // Random limit excursion
  logic        equil = 1'b0;      // Sensors settled
  logic        lock_nv = 1'b0;    // Stored lock
  logic        reply_en = 1'b0;   // Network in reach
  logic [6:0]  rssi_set = 7'h00;  // Strength to report
  logic [3:0]  delay = 4'h3;      // Partner answer delay
  logic        pready_o, pslverr_o, tx_done, tx_reply, radio_adv_o, powered_o, awake_o, lock_nv_o;
  logic [31:0] prdata_o, rd;      // Read data
  logic [6:0]  rssi, strength_o;  // Strengths
  logic [7:0]  clicks_o;          // Click count
  logic        err;               // Slave error
  mode_ctrl_pkg::wake_pins_s pins = '0;  // Wake pins
  mode_ctrl_pkg::mode_e      mode_o;     // Mode
  mode_ctrl_pkg::glyph_e     glyph_o;    // Glyph
  mode_ctrl_pkg::strobes_s   strobes;    // Pulses
  int errors = 0, check_count = 0, seed = 7, log_cnt = 0, cal_cnt = 0, wakes = 0, base;
  int exp_mode, exp_glyph;  // Model state, glyph -1 when free
  // Mode codes for the reference model
  localparam int RUN = mode_ctrl_pkg::MODE_RUN, OFF = mode_ctrl_pkg::MODE_OFF;
  localparam int LOCK = mode_ctrl_pkg::MODE_LOCK, RADIO = mode_ctrl_pkg::MODE_RADIO;
  // ----------
  // Clock, random sensor input, pulse counters
  // ----------
  always #5 ref_clk_i = !ref_clk_i;
  always @(posedge ref_clk_i)
  begin
    limit_q <= 1'($random(seed));
    wakes   <= wakes + awake_o;
    log_cnt <= log_cnt + strobes.log_rec;
    cal_cnt <= cal_cnt + strobes.cal_pt;
  end
  button_mode_controller button_mode_controller_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .pins_i(pins),
    .limit_exceed_i(limit_q), .tx_done_i(tx_done), .tx_reply_i(tx_reply), .rssi_pct_i(rssi),
    .resend_i(1'b0), .radio_conn_i(1'b0), .equil_i(equil), .lock_nv_i(lock_nv), .lock_nv_o(lock_nv_o),
    .mode_o(mode_o), .glyph_o(glyph_o), .clicks_o(clicks_o), .strength_o(strength_o),
    .radio_adv_o(radio_adv_o), .powered_o(powered_o), .awake_o(awake_o), .strobes_o(strobes));
  radio_partner radio_partner_inst (.ref_clk_i(ref_clk_i), .strobes_i(strobes), .reply_en_i(reply_en),
    .rssi_set_i(rssi_set), .delay_i(delay), .tx_done_o(tx_done), .tx_reply_o(tx_reply), .rssi_o(rssi));
  // ----------
  // Tasks
  // ----------
  task automatic conclude();
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_up();
    errors++;
    conclude();
  endtask
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge ref_clk_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 20) give_up();
    rd = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait on mode (0) or glyph (1) reaching a value
  task automatic await(input bit on_glyph, input logic [31:0] val, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(posedge ref_clk_i);
      if ((on_glyph ? 32'(glyph_o) : 32'(mode_o)) === val) break;
    end
    if (i == lim) give_up();
  endtask
  task automatic reboot();
    srst_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
  endtask
  // Presses spaced well inside the click idle window
  task automatic press(input int k);
    repeat (k)
    begin
      @(posedge ref_clk_i) pins.button <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      pins.button <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
    end
  endtask
  // Reference decision on a finished count
  task automatic model(input int k);
    int m;
    m = exp_mode;
    exp_glyph = -1;
    if (m == OFF)
      m = k >= 20 ? LOCK : k >= 10 ? RUN : m;
    else if (m == LOCK)
      m = k >= 20 ? OFF : m;
    else if (k >= 10)
      m = OFF;
    else if (k == 1)
      m = RADIO;
    if (m == OFF) exp_glyph = mode_ctrl_pkg::GLYPH_OFF;
    if (m == LOCK) exp_glyph = mode_ctrl_pkg::GLYPH_SHIPPING_HOLD;
    if (m != exp_mode && m == RUN) exp_glyph = mode_ctrl_pkg::GLYPH_RUN;
    if (m == RADIO) exp_glyph = mode_ctrl_pkg::GLYPH_READINGS;
    if (k == 2 && m == RUN) exp_glyph = mode_ctrl_pkg::GLYPH_TRANSMIT;
    exp_mode = m;
  endtask
  task automatic clicks(input int k);
    int i;
    press(k);
    check(32'(clicks_o), k);
    for (i = 0; i < 400 && clicks_o !== 8'h00; i++) @(posedge ref_clk_i);
    if (i == 400) give_up();
    repeat (2) @(posedge ref_clk_i);
    model(k);
    check(32'(mode_o), exp_mode);
    if (exp_glyph >= 0) check(32'(glyph_o), exp_glyph);
  endtask
  // ----------
  // Scenarios
  // ----------
  initial
  begin
    exp_mode = OFF;
    reboot();
    apb(1'b0, mode_ctrl_pkg::ADDR_IDLE, 32'h0);
    check(rd, mode_ctrl_pkg::IDLE_RST);
    apb(1'b1, mode_ctrl_pkg::ADDR_IDLE, 32'h0000_0008);
    apb(1'b1, mode_ctrl_pkg::ADDR_TOUT, 32'h0000_0014);
    apb(1'b1, mode_ctrl_pkg::ADDR_CTRL, 32'h0000_0003);
    apb(1'b0, 8'h40, 32'h0);
    check(32'(err), 32'h1);
    clicks(1 + $unsigned($random(seed)) % 9);
    check(32'(powered_o), 32'h0);
    clicks(12);
    check(32'(wakes > 0), 32'h1);
    reply_en <= 1'b1;
    rssi_set <= 7'($random(seed));
    delay <= 4'($random(seed));
    clicks(2);
    await(1'b1, mode_ctrl_pkg::GLYPH_STRENGTH, 40);
    check(32'(strength_o), rssi_set > mode_ctrl_pkg::PCT_MAX ? mode_ctrl_pkg::PCT_MAX : rssi_set);
    reply_en <= 1'b0;
    clicks(2);
    await(1'b1, mode_ctrl_pkg::GLYPH_NO_NETWORK, 40);
    check(32'(glyph_o), mode_ctrl_pkg::GLYPH_NO_NETWORK);
    base = log_cnt;
    clicks(1);
    check(32'(log_cnt > base), 32'h1);
    await(1'b0, RUN, 80);
    check(32'(radio_adv_o), 32'h0);
    exp_mode = RUN;
    pins.optic <= 1'b1;
    await(1'b1, mode_ctrl_pkg::GLYPH_OPEN, 20);
    check(32'(glyph_o), mode_ctrl_pkg::GLYPH_OPEN);
    base = cal_cnt;
    pins.dongle <= 1'b1;
    equil <= 1'b1;
    await(1'b0, mode_ctrl_pkg::MODE_CAL, 20);
    press(3);
    check(32'(clicks_o), 32'h0);
    await(1'b0, RUN, 100);
    check(cal_cnt - base, 32'hA);
    clicks(10);
    clicks(20);
    clicks(5);
    check(32'(lock_nv_o), 32'h1);
    lock_nv <= 1'b1;
    reboot();
    check(32'(mode_o), LOCK);
    clicks(20);
    conclude();
  end
endmodule
`default_nettype wire
